// ---- logic/genset_pkg.sv ----
// Package: register map, reset values and timing constants for load management
package genset_pkg;

   // Clock and time base
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_TIME_MS = 10;
   localparam int TICK_CYCLES = (TICK_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int PULSE_TIME_MS = 250;
   localparam int PULSE_TICKS_INT = PULSE_TIME_MS / TICK_TIME_MS;
   localparam logic [7:0] PULSE_TICKS = PULSE_TICKS_INT[7:0];

   // Widths
   localparam int PWR_W = 16;
   localparam int TIME_W = 16;
   localparam int STEPS = 5;
   localparam int NUM_DOUT = 8;
   localparam int SEL_W = 3;

   // Register byte offsets
   localparam logic [7:0] SHED_HIGH_OFS = 8'h00;
   localparam logic [7:0] SHED_LOW_OFS = 8'h04;
   localparam logic [7:0] ADD_LEVEL_OFS = 8'h08;
   localparam logic [7:0] SUB_LEVEL_OFS = 8'h0c;
   localparam logic [7:0] STEP_DELAY_OFS = 8'h10;
   localparam logic [7:0] CROSS_DELAY_OFS = 8'h14;
   localparam logic [7:0] INC_QUAL_OFS = 8'h18;
   localparam logic [7:0] INC_WAIT_OFS = 8'h1c;
   localparam logic [7:0] DEC_QUAL_OFS = 8'h20;
   localparam logic [7:0] DEC_WAIT_OFS = 8'h24;
   localparam logic [7:0] ROUTE_OFS = 8'h28;
   localparam logic [7:0] STATUS_OFS = 8'h2c;

   // Reset values (power in raw units, times in ticks)
   localparam logic [15:0] SHED_HIGH_RST = 16'h0384;
   localparam logic [15:0] SHED_LOW_RST = 16'h012c;
   localparam logic [15:0] ADD_LEVEL_RST = 16'h00c8;
   localparam logic [15:0] SUB_LEVEL_RST = 16'h03e8;
   localparam logic [15:0] STEP_DELAY_RST = 16'h00c8;
   localparam logic [15:0] CROSS_DELAY_RST = 16'h012c;
   localparam logic [15:0] QUAL_RST = 16'h0064;
   localparam logic [15:0] WAIT_RST = 16'h01f4;
   localparam logic [23:0] ROUTE_RST = 24'h000000;
   localparam logic [15:0] TIME_MAX = 16'hffff;

   // Output routing sources
   typedef enum logic [2:0] {
      SRC_OFF, SRC_SHED, SRC_DUMMY, SRC_INC, SRC_DEC, SRC_ANY_ADD, SRC_ANY_SUB, SRC_ON
   } source_type;

endpackage

// ---- logic/hold_counter.sv ----
// Qualification timer: counts ticks while a condition holds continuously
`timescale 1ns/10ps
module hold_counter (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic tick,
   input wire logic hold,
   input wire logic restart,
   input wire logic [genset_pkg::TIME_W-1:0] limit,
   output logic done
);
   import genset_pkg::*;

   typedef struct packed {
      logic [TIME_W-1:0] cnt;
      logic done;
   } hold_state_type;

   hold_state_type st_q;
   hold_state_type st_d;

   always_comb begin
      st_d = st_q;
      // Any break in the condition starts the wait over
      if (!hold || restart) begin
         st_d.cnt = '0;
      end else if (tick && st_q.cnt < limit) begin
         st_d.cnt = st_q.cnt + 1'b1;
      end
      st_d.done = hold && !restart && (st_d.cnt >= limit);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign done = st_q.done;
endmodule

// ---- logic/genset_load_management.sv ----
// Load shedding, step add/subtract and five-step load sequencer with APB registers
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module genset_load_management #(
   parameter int TICK_CYCLES = genset_pkg::TICK_CYCLES
) (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [genset_pkg::PWR_W-1:0] POWER,
   output logic SHED_OUT,
   output logic DUMMY_OUT,
   output logic STEP_INC,
   output logic STEP_DEC,
   output logic [genset_pkg::STEPS-1:0] LOAD_ADD,
   output logic [genset_pkg::STEPS-1:0] LOAD_SUB,
   output logic [genset_pkg::NUM_DOUT-1:0] DOUT
);
   import genset_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [15:0] shed_high;
      logic [15:0] shed_low;
      logic [15:0] add_level;
      logic [15:0] sub_level;
      logic [15:0] step_delay;
      logic [15:0] cross_delay;
      logic [15:0] increase_qualify_time;
      logic [15:0] increase_wait_time;
      logic [15:0] decrease_qualify_time;
      logic [15:0] decrease_wait_time;
      logic [23:0] route;
      logic [31:0] presc;
      logic tick;
      logic [15:0] since_inc;
      logic [15:0] since_dec;
      logic [15:0] since_add;
      logic [15:0] since_sub;
      logic shed;
      logic dummy;
      logic inc;
      logic dec;
      logic [2:0] count;
      logic [7:0] pulse_left;
      logic [STEPS-1:0] add_out;
      logic [STEPS-1:0] sub_out;
      logic [NUM_DOUT-1:0] dout;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } state_type;

   state_type st_q;
   state_type st_d;

   logic add_ready;
   logic sub_ready;
   logic fire_add;
   logic fire_sub;
   logic [NUM_DOUT-1:0] dout_d;
   logic [7:0] src_vec;

   localparam logic [2:0] STEPS_MAX = 3'(STEPS);
   localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Qualification timers

   hold_counter add_qual (
      .clk(MCLK),
      .rstn(RSTN),
      .ce(CE),
      .tick(st_q.tick),
      .hold(POWER < st_q.add_level),
      .restart(fire_add),
      .limit(st_q.increase_qualify_time),
      .done(add_ready)
   );

   hold_counter sub_qual (
      .clk(MCLK),
      .rstn(RSTN),
      .ce(CE),
      .tick(st_q.tick),
      .hold(POWER > st_q.sub_level),
      .restart(fire_sub),
      .limit(st_q.decrease_qualify_time),
      .done(sub_ready)
   );

   // One step at a time; a pulse in flight blocks the next decision
   assign fire_add = add_ready && (st_q.since_add >= st_q.increase_wait_time)
                     && (st_q.count < STEPS_MAX) && (st_q.pulse_left == 8'h00);
   assign fire_sub = sub_ready && (st_q.since_sub >= st_q.decrease_wait_time)
                     && (st_q.count != 3'h0) && (st_q.pulse_left == 8'h00)
                     && !fire_add;

   ////////////////////////////////////////////////////////////////////////////
   // Output routing, one selector per digital output

   assign src_vec = {1'b1, |st_q.sub_out, |st_q.add_out, st_q.dec, st_q.inc,
                     st_q.dummy, st_q.shed, 1'b0};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_DOUT; gi++) begin : g_route
         assign dout_d[gi] = src_vec[st_q.route[gi*SEL_W +: SEL_W]];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic t);
      if (t && v != TIME_MAX) begin
         return v + 16'h0001;
      end
      return v;
   endfunction

   always_comb begin
      st_d = st_q;

      // Time base
      st_d.tick = 1'b0;
      if (st_q.presc >= TICK_LAST) begin
         st_d.presc = '0;
         st_d.tick = 1'b1;
      end else begin
         st_d.presc = st_q.presc + 32'h1;
      end

      st_d.since_inc = sat_inc(st_q.since_inc, st_q.tick);
      st_d.since_dec = sat_inc(st_q.since_dec, st_q.tick);
      st_d.since_add = sat_inc(st_q.since_add, st_q.tick);
      st_d.since_sub = sat_inc(st_q.since_sub, st_q.tick);

      // Hysteretic shedding, no enable bit on purpose
      if (POWER > st_q.shed_high) begin
         st_d.shed = 1'b1;
      end else if (POWER < st_q.shed_low) begin
         st_d.shed = 1'b0;
      end
      st_d.dummy = !st_d.shed;

      // Step increase: level output, gated only at its rising edge
      if (POWER >= st_q.shed_low) begin
         st_d.inc = 1'b0;
      end else if (!st_q.inc && st_q.since_inc >= st_q.step_delay
                   && st_q.since_dec >= st_q.cross_delay) begin
         st_d.inc = 1'b1;
         st_d.since_inc = '0;
      end

      // Step decrease, mirror image; the external system closes the loop
      if (POWER <= st_q.shed_high) begin
         st_d.dec = 1'b0;
      end else if (!st_q.dec && st_q.since_dec >= st_q.step_delay
                   && st_q.since_inc >= st_q.cross_delay) begin
         st_d.dec = 1'b1;
         st_d.since_dec = '0;
      end

      // Five-step sequencer
      if (st_q.pulse_left != 8'h00) begin
         if (st_q.tick) begin
            st_d.pulse_left = st_q.pulse_left - 8'h01;
         end
         if (st_d.pulse_left == 8'h00) begin
            st_d.add_out = '0;
            st_d.sub_out = '0;
         end
      end
      if (fire_add) begin
         st_d.add_out = '0;
         st_d.add_out[st_q.count] = 1'b1;
         st_d.count = st_q.count + 3'h1;
         st_d.pulse_left = PULSE_TICKS;
         st_d.since_add = '0;
      end else if (fire_sub) begin
         st_d.sub_out = '0;
         st_d.sub_out[st_q.count - 3'h1] = 1'b1;
         st_d.count = st_q.count - 3'h1;
         st_d.pulse_left = PULSE_TICKS;
         st_d.since_sub = '0;
      end

      st_d.dout = dout_d;

      // APB slave: answer prepared in setup, so access completes at once
      st_d.pready = 1'b0;
      if (PSEL && !PENABLE) begin
         st_d.pready = 1'b1;
         st_d.pslverr = 1'b0;
         st_d.prdata = '0;
         unique case (PADDR)
            SHED_HIGH_OFS: st_d.prdata[15:0] = st_q.shed_high;
            SHED_LOW_OFS: st_d.prdata[15:0] = st_q.shed_low;
            ADD_LEVEL_OFS: st_d.prdata[15:0] = st_q.add_level;
            SUB_LEVEL_OFS: st_d.prdata[15:0] = st_q.sub_level;
            STEP_DELAY_OFS: st_d.prdata[15:0] = st_q.step_delay;
            CROSS_DELAY_OFS: st_d.prdata[15:0] = st_q.cross_delay;
            INC_QUAL_OFS: st_d.prdata[15:0] = st_q.increase_qualify_time;
            INC_WAIT_OFS: st_d.prdata[15:0] = st_q.increase_wait_time;
            DEC_QUAL_OFS: st_d.prdata[15:0] = st_q.decrease_qualify_time;
            DEC_WAIT_OFS: st_d.prdata[15:0] = st_q.decrease_wait_time;
            ROUTE_OFS: st_d.prdata[23:0] = st_q.route;
            STATUS_OFS: st_d.prdata[16:0] = {st_q.sub_out, st_q.add_out, st_q.count,
                                              st_q.dec, st_q.inc, st_q.dummy, st_q.shed};
            default: st_d.pslverr = 1'b1;
         endcase
      end
      if (PSEL && PENABLE && st_q.pready && PWRITE) begin
         unique case (PADDR)
            SHED_HIGH_OFS: st_d.shed_high = PWDATA[15:0];
            SHED_LOW_OFS: st_d.shed_low = PWDATA[15:0];
            ADD_LEVEL_OFS: st_d.add_level = PWDATA[15:0];
            SUB_LEVEL_OFS: st_d.sub_level = PWDATA[15:0];
            STEP_DELAY_OFS: st_d.step_delay = PWDATA[15:0];
            CROSS_DELAY_OFS: st_d.cross_delay = PWDATA[15:0];
            INC_QUAL_OFS: st_d.increase_qualify_time = PWDATA[15:0];
            INC_WAIT_OFS: st_d.increase_wait_time = PWDATA[15:0];
            DEC_QUAL_OFS: st_d.decrease_qualify_time = PWDATA[15:0];
            DEC_WAIT_OFS: st_d.decrease_wait_time = PWDATA[15:0];
            ROUTE_OFS: st_d.route = PWDATA[23:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         st_q <= '0;
         st_q.shed_high <= SHED_HIGH_RST;
         st_q.shed_low <= SHED_LOW_RST;
         st_q.add_level <= ADD_LEVEL_RST;
         st_q.sub_level <= SUB_LEVEL_RST;
         st_q.step_delay <= STEP_DELAY_RST;
         st_q.cross_delay <= CROSS_DELAY_RST;
         st_q.increase_qualify_time <= QUAL_RST;
         st_q.increase_wait_time <= WAIT_RST;
         st_q.decrease_qualify_time <= QUAL_RST;
         st_q.decrease_wait_time <= WAIT_RST;
         st_q.route <= ROUTE_RST;
         // Guard timers start expired so the first decision is not delayed
         st_q.since_inc <= TIME_MAX;
         st_q.since_dec <= TIME_MAX;
         st_q.since_add <= TIME_MAX;
         st_q.since_sub <= TIME_MAX;
         st_q.dummy <= 1'b1;
      end else if (CE) begin
         st_q <= st_d;
      end
   end

   assign PRDATA = st_q.prdata;
   assign PREADY = st_q.pready;
   assign PSLVERR = st_q.pslverr;
   assign SHED_OUT = st_q.shed;
   assign DUMMY_OUT = st_q.dummy;
   assign STEP_INC = st_q.inc;
   assign STEP_DEC = st_q.dec;
   assign LOAD_ADD = st_q.add_out;
   assign LOAD_SUB = st_q.sub_out;
   assign DOUT = st_q.dout;
endmodule

// ---- verif/genset_checker_sva.sv ----
// Checker: concurrent assertions on the load management ports
`timescale 1ns/10ps
module genset_checker #(
   parameter int TICK_CYCLES = 4
) (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic PREADY,
   input wire logic [genset_pkg::PWR_W-1:0] POWER,
   input wire logic SHED_OUT,
   input wire logic DUMMY_OUT,
   input wire logic STEP_INC,
   input wire logic STEP_DEC,
   input wire logic [genset_pkg::STEPS-1:0] LOAD_ADD,
   input wire logic [genset_pkg::STEPS-1:0] LOAD_SUB
);
   import genset_pkg::*;
   localparam int WMIN = (PULSE_TICKS_INT - 1) * TICK_CYCLES;
   localparam int WMAX = PULSE_TICKS_INT * TICK_CYCLES + 2;
   logic [15:0] high_q;
   logic [15:0] low_q;
   logic [2:0] cnt_q;
   logic add_q;
   logic sub_q;
   int wid_q;
   logic wr;
   ////////////////////////////////////////////////////////////////////////////
   // Thresholds mirrored from bus writes, step count from pulse edges
   assign wr = CE && PSEL && PENABLE && PREADY && PWRITE;
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         high_q <= SHED_HIGH_RST;
         low_q <= SHED_LOW_RST;
         cnt_q <= 3'h0;
         add_q <= 1'b0;
         sub_q <= 1'b0;
         wid_q <= 0;
      end else begin
         if (wr && PADDR == SHED_HIGH_OFS) high_q <= PWDATA[15:0];
         if (wr && PADDR == SHED_LOW_OFS) low_q <= PWDATA[15:0];
         add_q <= |LOAD_ADD;
         sub_q <= |LOAD_SUB;
         if (|LOAD_ADD && !add_q) cnt_q <= cnt_q + 3'h1;
         else if (|LOAD_SUB && !sub_q) cnt_q <= cnt_q - 3'h1;
         wid_q <= (|{LOAD_ADD, LOAD_SUB}) ? wid_q + 1 : 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   a_shed_set: assert property (CE && POWER > high_q |=> SHED_OUT)
      else $error("shed output not set above high level");
   a_shed_clear: assert property (CE && POWER < low_q |=> !SHED_OUT)
      else $error("shed output not cleared below low level");
   a_dummy_inverse: assert property (DUMMY_OUT == !SHED_OUT)
      else $error("dummy output not inverse of shed");
   a_inc_off: assert property (CE && POWER >= low_q |=> !STEP_INC)
      else $error("step increase active at or above low level");
   a_dec_off: assert property (CE && POWER <= high_q |=> !STEP_DEC)
      else $error("step decrease active at or below high level");
   a_add_order: assert property ($rose(|LOAD_ADD) |-> LOAD_ADD == 5'h01 << cnt_q)
      else $error("add pulse on wrong step");
   a_sub_order: assert property ($rose(|LOAD_SUB) |-> cnt_q != 3'h0 &&
      LOAD_SUB == 5'h01 << (cnt_q - 3'h1))
      else $error("subtract pulse on wrong step");
   a_pulse_width: assert property ($fell(|{LOAD_ADD, LOAD_SUB}) |->
      wid_q >= WMIN && wid_q <= WMAX)
      else $error("step pulse width out of range");
endmodule
bind genset_load_management genset_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
   .MCLK(MCLK), .RSTN(RSTN), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .POWER(POWER), .SHED_OUT(SHED_OUT),
   .DUMMY_OUT(DUMMY_OUT), .STEP_INC(STEP_INC), .STEP_DEC(STEP_DEC), .LOAD_ADD(LOAD_ADD),
   .LOAD_SUB(LOAD_SUB));

// ---- verif/load_plant.sv ----
// Partner model: load switching system that follows the step outputs
`timescale 1ns/10ps
module load_plant (
   input wire logic clk,
   input wire logic follow,
   input wire logic set_en,
   input wire logic [15:0] set_val,
   input wire logic [3:0] rate,
   input wire logic step_inc,
   input wire logic step_dec,
   output logic [15:0] power
);
   // Rate sets prompt or slow response; bench override wins over following
   always_ff @(posedge clk) begin
      if (set_en) power <= set_val;
      else if (follow && step_inc) power <= power + 16'(rate);
      else if (follow && step_dec) power <= power - 16'(rate);
   end
endmodule

// ---- verif/genset_load_management_bench.sv ----
// Testbench: registers, shedding, step outputs and load sequencer
`timescale 1ns/10ps
module genset_load_management_bench;
   import genset_pkg::*;
   localparam int TC = 4;
   logic MCLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er, follow, set_en;
   logic SHED_OUT, DUMMY_OUT, STEP_INC, STEP_DEC;
   logic [7:0] PADDR, DOUT;
   logic [31:0] PWDATA, PRDATA, rd;
   logic [15:0] POWER, set_val;
   logic [3:0] rate;
   logic [4:0] LOAD_ADD, LOAD_SUB;
   logic [6:0] mon;
   int fails = 0, comparisons = 0, cyc = 0, t, tp, ti, td;
   int cfg[6] = '{5, 8, 5, 30, 5, 30};
   int pw[5] = '{950, 600, 250, 600, 950};
   logic [4:0] sh = 5'b10011;
   logic [31:0] rst_tab[12] = '{32'(SHED_HIGH_RST), 32'(SHED_LOW_RST), 32'(ADD_LEVEL_RST),
      32'(SUB_LEVEL_RST), 32'(STEP_DELAY_RST), 32'(CROSS_DELAY_RST), 32'(QUAL_RST),
      32'(WAIT_RST), 32'(QUAL_RST), 32'(WAIT_RST), 32'h0, 32'h2};
   assign mon = {~|{LOAD_ADD, LOAD_SUB}, |LOAD_SUB, |LOAD_ADD, !STEP_DEC, !STEP_INC,
      STEP_DEC, STEP_INC};
   genset_load_management #(.TICK_CYCLES(TC)) uut (.MCLK(MCLK), .RSTN(RSTN), .CE(1'b1),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .POWER(POWER), .SHED_OUT(SHED_OUT),
      .DUMMY_OUT(DUMMY_OUT), .STEP_INC(STEP_INC), .STEP_DEC(STEP_DEC), .LOAD_ADD(LOAD_ADD),
      .LOAD_SUB(LOAD_SUB), .DOUT(DOUT));
   load_plant plant (.clk(MCLK), .follow(follow), .set_en(set_en), .set_val(set_val),
      .rate(rate), .step_inc(STEP_INC), .step_dec(STEP_DEC), .power(POWER));
   ////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      // Idle edge first so the previous release is never overwritten in one step
      @(posedge MCLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge MCLK);
         n++;
      end while (PREADY !== 1'b1 && n < 50);
      if (n >= 50) fails++;
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bounded wait; t stays -1 when the monitored condition never shows
   task automatic wait_on(input int s, input int lim, output int tt);
      tt = -1;
      for (int i = 0; i < lim && tt < 0; i++) begin
         @(posedge MCLK);
         if (mon[s] === 1'b1) tt = cyc;
      end
   endtask
   task automatic set_pwr(input logic [15:0] v);
      @(posedge MCLK);
      set_val <= v;
      set_en <= 1'b1;
      @(posedge MCLK);
      set_en <= 1'b0;
   endtask
   task automatic print_verdict;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      MCLK = 1'b0;
      forever #50 MCLK = ~MCLK;
   end
   always @(posedge MCLK) cyc <= cyc + 1;
   initial begin
      repeat (20000) @(posedge MCLK);
      fails++;
      print_verdict;
   end
   initial begin
      {RSTN, PSEL, PENABLE, PWRITE, follow, set_en, PADDR, PWDATA} = '0;
      set_val = 16'd600;
      rate = 4'h1;
      set_en = 1'b1;
      repeat (4) @(posedge MCLK);
      RSTN <= 1'b1;
      @(posedge MCLK);
      for (int i = 0; i < 12; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(rd, rst_tab[i]);
      end
      apb(1'b0, 8'h30, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 8'(16 + 4 * i), cfg[i]);
         apb(1'b0, 8'(16 + 4 * i), 32'h0);
         chk(rd, cfg[i]);
      end
      apb(1'b1, STATUS_OFS, 32'hffffffff);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, ROUTE_OFS, 32'h00fac688);
      for (int i = 0; i < 5; i++) begin
         set_pwr(16'(pw[i]));
         // Routed outputs trail the shed flop by one register
         repeat (3) @(posedge MCLK);
         chk({SHED_OUT, DUMMY_OUT, DOUT[7], DOUT[2:0]}, {sh[i], !sh[i], 1'b1, !sh[i], sh[i], 1'b0});
      end
      // Slow follower first, then prompt one so the guards decide the timing
      set_pwr(16'd600);
      follow <= 1'b1;
      set_pwr(16'd250);
      wait_on(0, 200, ti);
      wait_on(2, 200, t);
      chk(32'(POWER >= 16'd300 && POWER <= 16'd302), 32'h1);
      rate <= 4'hf;
      set_pwr(16'd250);
      wait_on(0, 200, ti);
      set_pwr(16'd950);
      wait_on(1, 200, td);
      chk(32'(ti > 0 && td - ti >= 28), 32'h1);
      wait_on(3, 200, t);
      set_pwr(16'd950);
      wait_on(1, 200, t);
      chk(32'(t > 0 && t - td >= 16), 32'h1);
      follow <= 1'b0;
      set_pwr(16'd250);
      set_pwr(16'd600);
      wait_on(0, 60, t);
      chk(t, -1);
      set_pwr(16'd150);
      repeat (12) @(posedge MCLK);
      set_pwr(16'd600);
      set_pwr(16'd150);
      t = cyc;
      for (int k = 0; k < 6; k++) begin
         tp = t;
         wait_on(6, 200, t);
         wait_on(4, 400, t);
         if (k < 5) chk(LOAD_ADD, 5'h01 << k);
         if (k < 5) chk(32'(t - tp >= (k == 0 ? 16 : 116)), 32'h1);
         else chk(t, -1);
      end
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(32'(rd[6:4]), 32'h5);
      set_pwr(16'd1100);
      t = cyc;
      for (int k = 0; k < 6; k++) begin
         tp = t;
         wait_on(6, 200, t);
         wait_on(5, 400, t);
         if (k < 5) chk(LOAD_SUB, 5'h10 >> k);
         if (k < 5) chk(32'(t - tp >= (k == 0 ? 16 : 116)), 32'h1);
         else chk(t, -1);
      end
      print_verdict;
   end
endmodule
